// [hdl/sar_adc_cfg.svh]
// Register layout, field positions and timing counts for the converter control block
// How it works
// - The mux selects one of 16 sources from the 4-bit input-select field.
// - Each conversion is eight compare steps, MSB first, one bit each.
// - At conversion end the approximation value goes to its run-position result register.
// - Charge pump runs only while power-on is set; allow 100 us settling.
// - Sample switch closes only for 12 cycles at each conversion start.
// - Four readable 8-bit result registers hold the latest run.
// - Result updates never collide with CPU reads.
// - Clock-select 0 picks E clock, 1 picks the RC oscillator, for converter and NVM.
// - Runs are four conversions; continuous repeats, otherwise stop after one.
// - Sequence-done flag sets after the fourth conversion of a run.
// - Option bit 7 powers the converter up when set, down when clear.
// - On E clock, switching and comparator sampling are synchronous to the clock.
// - Stop-exit delay set holds restart about 4000 cycles, else about four.
// - A run begins two cycles after a control/status write, which sets input and mode.
// - Results are unsigned 8-bit, saturating at 0xff with no overflow flag.
// - Codes 0-7 pick pins 0-7; in group mode pin n fills result n mod 4.
// - Codes 8-11 reserved; 12,13,14 are high, low, half reference; 15 reserved.
// - One control/status register holds select, flag, continuous and group bits.
// - Single-channel mode converts one input four times; continuous wraps to result 0.
// - Any control/status write clears the flag; while powered up it also restarts, abandoning the old run.
// - Group mode uses only the upper two select bits; lower two ignored.
// - In continuous mode the flag sets after the first run and stays set.
`ifndef SAR_ADC_CFG_SVH
`define SAR_ADC_CFG_SVH

// ----------------------------------------------------------------------
// Control/status register fields
// ----------------------------------------------------------------------
`define CTL_DONE_BIT     7
`define CTL_CONT_BIT     5
`define CTL_GROUP_BIT    4
`define CTL_SEL_MSB      3
`define CTL_RESET        8'h00
// ----------------------------------------------------------------------
// Option register fields
// ----------------------------------------------------------------------
`define OPT_PWR_BIT      7
`define OPT_CONV_CLOCK_SELECT_BIT     6
`define OPT_DLY_BIT      4
`define OPT_WMASK        8'hd0
`define OPT_RESET        8'h10
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SAMPLE_CYCLES    12
// Trial hold past the first cycle, covering the two-flop comparator sync
`define COMP_SETTLE_CYC  2
`define CLK_MHZ          50
`define STOP_DELAY_CYC   4000
`define STOP_FAST_CYC    4
`define PUMP_SETTLE_US   100
`define PUMP_SETTLE_CYC  (`PUMP_SETTLE_US * `CLK_MHZ)
// Mux codes for the internal points
`define SEL_REF_HIGH     4'hc
`define SEL_REF_LOW      4'hd
`define SEL_REF_HALF     4'he

`endif

// [hdl/sar_adc_pkg.sv]
// Types shared by the converter control block
package sar_adc_pkg;
  typedef enum logic [1:0] {
    st_idle   = 2'b00,
    st_sample = 2'b01,
    st_steps  = 2'b11,
    st_store  = 2'b10
  } seq_state_type;

  typedef struct packed {
    logic [7:0] data;
    logic       wr;
    logic       rd;
  } cpu_access_type;

  typedef struct packed {
    logic [3:0] mux_select;
    logic       sample_closed;
    logic       pump_on;
    logic       clock_select;
  } analog_ctl_type;
endpackage : sar_adc_pkg

// [hdl/sar_step.sv]
// One successive-approximation register with MSB-first bit trials
`timescale 1ns/1ps
`default_nettype none
module sar_step #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // Control
  input  wire logic             start,
  input  wire logic             step,
  input  wire logic             comp_high,
  // Result
  output logic [WIDTH-1:0]      trial,
  output logic                  last
);
  logic [WIDTH-1:0] mask;
  logic [WIDTH-1:0] next_trial;
  logic [WIDTH-1:0] next_mask;

  // Keep the trial bit if the input is above the DAC level, then try the next
  always_comb begin
    next_trial = trial;
    next_mask  = mask;
    if (start) begin
      next_mask  = {1'b1, {(WIDTH-1){1'b0}}};
      next_trial = {1'b1, {(WIDTH-1){1'b0}}};
    end else if (step && mask != '0) begin
      if (!comp_high)
        next_trial = trial & ~mask;
      next_mask  = mask >> 1;
      next_trial = next_trial | (mask >> 1);
    end
  end

  // Saturation is natural: all ones when the input tops the high reference
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      trial <= '0;
      mask  <= '0;
    end else begin
      trial <= next_trial;
      mask  <= next_mask;
    end
  end

  assign last = (mask == {{(WIDTH-1){1'b0}}, 1'b1});
endmodule : sar_step
`default_nettype wire

// [hdl/sar_adc_sequencer_control.sv]
// Sequencer, control/status, option bits and result storage for the converter
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_cfg.svh"
module sar_adc_sequencer_control
  import sar_adc_pkg::*;
#(
  parameter int SAMPLE_CYCLES = `SAMPLE_CYCLES,
  parameter int STOP_DELAY    = `STOP_DELAY_CYC
) (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          rst_n,
  // Control/status register access
  input  wire cpu_access_type ctl_access,
  output logic [7:0]         ctl_rdata,
  // Option register access
  input  wire cpu_access_type opt_access,
  output logic [7:0]         opt_rdata,
  // Result register reads
  input  wire logic [1:0]    result_index,
  output logic [7:0]         result_rdata,
  // Comparator from the analog array (asynchronous)
  input  wire logic          comparator_in,
  // Stop mode
  input  wire logic          stop_exit,
  output logic               stop_hold,
  // Analog side controls
  output var analog_ctl_type analog_ctl,
  output logic [7:0]         dac_trial,
  output logic               sequence_done_flag
);
  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic [3:0]    input_select_field;
  logic          group_mode;
  logic          continuous;
  logic          converter_power_on;
  logic          conv_clock_select;
  logic          stop_exit_delay_enable;
  logic [7:0]    result_reg [4];
  logic          start_pending;
  logic          next_start_pending;
  logic [7:0]    next_result_reg [4];
  logic          next_flag;

  seq_state_type state;
  seq_state_type next_state;
  logic [3:0]    sample_cnt;
  logic [3:0]    next_sample_cnt;
  logic [1:0]    position;
  logic [1:0]    next_position;
  logic          comp_meta;
  logic          comp_sync;
  logic          sar_start;
  logic          sar_last;
  logic [7:0]    sar_value;
  logic [12:0]   stop_cnt;
  logic [12:0]   next_stop_cnt;
  logic [1:0]    settle_cnt;
  logic [1:0]    next_settle_cnt;
  logic          sar_step_en;
  logic          next_power_on;
  logic          next_clock_select;
  logic          next_delay_enable;

  // ----------------------------------------------------------------------
  // Comparator synchroniser
  // ----------------------------------------------------------------------
  // Comparator settles inside a cycle; two flops make the sample point quiet
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
    end else begin
      comp_meta <= comparator_in;
      comp_sync <= comp_meta;
    end
  end

  // ----------------------------------------------------------------------
  // Option register
  // ----------------------------------------------------------------------
  // A write takes the three implemented bits; the rest are dropped
  always_comb begin
    next_power_on     = converter_power_on;
    next_clock_select = conv_clock_select;
    next_delay_enable = stop_exit_delay_enable;
    if (opt_access.wr) begin
      next_power_on     = opt_access.data[`OPT_PWR_BIT];
      next_clock_select = opt_access.data[`OPT_CONV_CLOCK_SELECT_BIT];
      next_delay_enable = opt_access.data[`OPT_DLY_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      converter_power_on     <= 1'(`OPT_RESET >> `OPT_PWR_BIT);
      conv_clock_select      <= 1'(`OPT_RESET >> `OPT_CONV_CLOCK_SELECT_BIT);
      stop_exit_delay_enable <= 1'(`OPT_RESET >> `OPT_DLY_BIT);
    end else begin
      converter_power_on     <= next_power_on;
      conv_clock_select      <= next_clock_select;
      stop_exit_delay_enable <= next_delay_enable;
    end
  end

  // Unimplemented option bits read zero
  always_comb begin
    opt_rdata                = 8'h00;
    opt_rdata[`OPT_PWR_BIT]  = converter_power_on;
    opt_rdata[`OPT_CONV_CLOCK_SELECT_BIT] = conv_clock_select;
    opt_rdata[`OPT_DLY_BIT]  = stop_exit_delay_enable;
  end

  // ----------------------------------------------------------------------
  // Control/status register
  // ----------------------------------------------------------------------
  // Mode bits are stored straight from the write; the flag has its own path
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      input_select_field <= 4'h0;
      group_mode         <= 1'b0;
      continuous         <= 1'b0;
    end else if (ctl_access.wr) begin
      input_select_field <= ctl_access.data[`CTL_SEL_MSB:0];
      group_mode         <= ctl_access.data[`CTL_GROUP_BIT];
      continuous         <= ctl_access.data[`CTL_CONT_BIT];
    end
  end

  // Bit 6 reads zero; flag is read-only
  always_comb begin
    ctl_rdata                  = 8'h00;
    ctl_rdata[`CTL_DONE_BIT]   = sequence_done_flag;
    ctl_rdata[`CTL_CONT_BIT]   = continuous;
    ctl_rdata[`CTL_GROUP_BIT]  = group_mode;
    ctl_rdata[`CTL_SEL_MSB:0]  = input_select_field;
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // A write arms a start that the sequencer takes on the next edge
  always_comb begin
    next_state        = state;
    next_sample_cnt   = sample_cnt;
    next_position     = position;
    next_start_pending = 1'b0;
    sar_start         = 1'b0;
    if (ctl_access.wr) begin
      next_start_pending = 1'b1;
      next_state         = st_idle;
    end else if (!converter_power_on) begin
      next_state = st_idle;
    end else begin
      unique case (state)
        st_idle: begin
          if (start_pending) begin
            next_state      = st_sample;
            next_sample_cnt = 4'h0;
            next_position   = 2'd0;
          end
        end
        st_sample: begin
          next_sample_cnt = sample_cnt + 4'h1;
          if (sample_cnt == 4'(SAMPLE_CYCLES - 1)) begin
            next_state = st_steps;
            sar_start  = 1'b1;
          end
        end
        st_steps: begin
          if (sar_step_en && sar_last)
            next_state = st_store;
        end
        st_store: begin
          next_position   = position + 2'd1;
          next_sample_cnt = 4'h0;
          if (position == 2'd3 && !continuous)
            next_state = st_idle;
          else
            next_state = st_sample;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state         <= st_idle;
      sample_cnt    <= 4'h0;
      position      <= 2'd0;
      start_pending <= 1'b0;
    end else begin
      state         <= next_state;
      sample_cnt    <= next_sample_cnt;
      position      <= next_position;
      start_pending <= next_start_pending;
    end
  end

  // ----------------------------------------------------------------------
  // Comparator pacing
  // ----------------------------------------------------------------------
  // The synchroniser lags two cycles, so each trial is held three cycles
  // before its bit is judged; stepping every cycle would judge the
  // comparator against the trial level of two steps back. Costs 16 cycles a result.
  always_comb begin
    next_settle_cnt = 2'd0;
    sar_step_en     = 1'b0;
    if (state == st_steps) begin
      if (settle_cnt == 2'(`COMP_SETTLE_CYC)) begin
        sar_step_en = 1'b1;
      end else begin
        next_settle_cnt = settle_cnt + 2'd1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n)
      settle_cnt <= 2'd0;
    else
      settle_cnt <= next_settle_cnt;
  end

  sar_step #(
    .WIDTH (8)
  ) u_sar (
    .clock     (clock),
    .rst_n     (rst_n),
    .start     (sar_start),
    .step      (sar_step_en),
    .comp_high (comp_sync),
    .trial     (sar_value),
    .last      (sar_last)
  );

  // ----------------------------------------------------------------------
  // Mux select and analog controls
  // ----------------------------------------------------------------------
  // Group mode replaces the low two select bits with the run position
  always_comb begin
    analog_ctl.mux_select = input_select_field;
    if (group_mode)
      analog_ctl.mux_select = {input_select_field[3:2], position};
    analog_ctl.sample_closed = (state == st_sample);
    analog_ctl.pump_on       = converter_power_on;
    analog_ctl.clock_select  = conv_clock_select;
  end

  assign dac_trial = sar_value;

  // ----------------------------------------------------------------------
  // Results and completion flag
  // ----------------------------------------------------------------------
  // Store edge is taken whether or not the CPU side reads a result; a read
  // that lands on the store cycle sees the old value, never a torn one
  always_comb begin
    for (int i = 0; i < 4; i++)
      next_result_reg[i] = result_reg[i];
    next_flag = sequence_done_flag;
    if (ctl_access.wr) begin
      next_flag = 1'b0;
    end else if (state == st_store && converter_power_on) begin
      next_result_reg[position] = sar_value;
      if (position == 2'd3)
        next_flag = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++)
        result_reg[i] <= 8'h00;
      sequence_done_flag <= 1'b0;
    end else begin
      for (int i = 0; i < 4; i++)
        result_reg[i] <= next_result_reg[i];
      sequence_done_flag <= next_flag;
    end
  end

  // Read data registered so a read never overlaps the update edge
  always_ff @(posedge clock) begin
    if (!rst_n)
      result_rdata <= 8'h00;
    else
      result_rdata <= result_reg[result_index];
  end

  // ----------------------------------------------------------------------
  // Stop exit delay
  // ----------------------------------------------------------------------
  // Long hold lets the oscillator settle; short hold is a few bus cycles
  always_comb begin
    next_stop_cnt = stop_cnt;
    if (stop_exit)
      next_stop_cnt = stop_exit_delay_enable ? 13'(STOP_DELAY)
                                             : 13'(`STOP_FAST_CYC);
    else if (stop_cnt != 13'h0)
      next_stop_cnt = stop_cnt - 13'h1;
  end

  always_ff @(posedge clock) begin
    if (!rst_n)
      stop_cnt <= 13'h0;
    else
      stop_cnt <= next_stop_cnt;
  end

  assign stop_hold = (stop_cnt != 13'h0);
endmodule : sar_adc_sequencer_control
`default_nettype wire

// [tb/sar_adc_properties.sv]
// Port checker for the converter sequencer, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module sar_adc_properties
  import sar_adc_pkg::*;
#(
  parameter int SAMPLE_CYCLES = 12,
  parameter int STOP_DELAY    = 4000
) (
  // Clock and reset
  input wire logic           clock,
  input wire logic           rst_n,
  // Register side
  input wire cpu_access_type ctl_access,
  input wire logic [7:0]     ctl_rdata,
  input wire cpu_access_type opt_access,
  input wire logic [7:0]     opt_rdata,
  input wire logic [1:0]     result_index,
  input wire logic [7:0]     result_rdata,
  // Analog and stop side
  input wire logic           comparator_in,
  input wire logic           stop_exit,
  input wire logic           stop_hold,
  input wire analog_ctl_type analog_ctl,
  input wire logic [7:0]     dac_trial,
  input wire logic           sequence_done_flag
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Length of the open sample window so far
  logic [7:0] scnt;
  logic [7:0] next_scnt;
  always_comb next_scnt = analog_ctl.sample_closed ? scnt + 8'h01 : 8'h00;
  always_ff @(posedge clock) scnt <= rst_n ? next_scnt : 8'h00;

  sample_window_a: assert property (!analog_ctl.sample_closed && $past(analog_ctl.sample_closed)
    && !$past(ctl_access.wr) && opt_rdata[7]
    |-> scnt == 8'(SAMPLE_CYCLES)) else $error("sample window length wrong");
  run_start_a: assert property (ctl_access.wr && opt_rdata[7]
    |-> ##[2:3] analog_ctl.sample_closed) else $error("run did not start after write");
  idle_off_a: assert property (!opt_rdata[7] [*2]
    |-> !analog_ctl.sample_closed) else $error("sampling while powered down");
  pump_follow_a: assert property (analog_ctl.pump_on == opt_rdata[7])
    else $error("pump does not follow power bit");
  clock_follow_a: assert property (analog_ctl.clock_select == opt_rdata[6])
    else $error("clock select does not follow option bit");
  flag_clear_a: assert property (ctl_access.wr && opt_rdata[7] |=> !sequence_done_flag)
    else $error("done flag survived a control write");
  flag_keep_a: assert property (sequence_done_flag && !ctl_access.wr |=> sequence_done_flag)
    else $error("done flag dropped without a write");
  group_mux_a: assert property (analog_ctl.sample_closed && ctl_rdata[4] && $stable(ctl_rdata)
    |-> analog_ctl.mux_select[3:2] == ctl_rdata[3:2]) else $error("group select wrong");
  single_mux_a: assert property (analog_ctl.sample_closed && !ctl_rdata[4] && $stable(ctl_rdata)
    |-> analog_ctl.mux_select == ctl_rdata[3:0]) else $error("single select wrong");
  stop_fast_a: assert property (stop_exit && !opt_rdata[4] |=> stop_hold [*4] ##1 !stop_hold)
    else $error("fast stop exit held too long");
endmodule : sar_adc_properties
bind sar_adc_sequencer_control sar_adc_properties #(
  .SAMPLE_CYCLES(SAMPLE_CYCLES), .STOP_DELAY(STOP_DELAY)
) i_sar_adc_properties (.clock, .rst_n, .ctl_access, .ctl_rdata, .opt_access, .opt_rdata,
  .result_index, .result_rdata, .comparator_in, .stop_exit, .stop_hold, .analog_ctl,
  .dac_trial, .sequence_done_flag);
`default_nettype wire

// [tb/analog_front_model.sv]
// Analog front model: pins, references, sample-and-hold and comparator
`timescale 1ns/1ps
`default_nettype none
module analog_front_model
  import sar_adc_pkg::*;
(
  // Clock
  input  wire logic           clock,
  // Levels and controls
  input  wire logic [7:0]     pin_level [8],
  input  wire analog_ctl_type analog_ctl,
  input  wire logic [7:0]     dac_trial,
  // Comparator
  output logic                comparator_in
);
  logic [7:0] source;
  logic [7:0] held = 8'h00;
  // Pins are seen only through the mux, never read digitally while sampling
  // One of 16 sources; reserved codes give a shifting junk level
  always_comb begin
    case (analog_ctl.mux_select)
      4'hc:    source = 8'hff;
      4'hd:    source = 8'h00;
      4'he:    source = 8'h80;
      default: source = analog_ctl.mux_select[3] ? ~held : pin_level[analog_ctl.mux_select[2:0]];
    endcase
  end
  // Charge follows the source only while the switch is closed and the pump runs
  always_ff @(posedge clock) begin
    if (analog_ctl.sample_closed && analog_ctl.pump_on) begin
      held <= source;
    end
  end
  // Held level at or above the trial keeps the bit, so results equal the level
  assign comparator_in = (held >= dac_trial);
endmodule : analog_front_model
`default_nettype wire

// [tb/test_sar_adc_sequencer_control.sv]
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
`define chk_eq(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module test_sar_adc_sequencer_control import sar_adc_pkg::*;;
  logic           clock = 1'b0;
  logic           rst_n = 1'b0;
  cpu_access_type ctl_access = '0;
  cpu_access_type opt_access = '0;
  logic [1:0]     result_index = 2'h0;
  logic           stop_exit = 1'b0;
  logic [7:0]     ctl_rdata, opt_rdata, result_rdata, dac_trial;
  logic           comparator_in, stop_hold, sequence_done_flag;
  analog_ctl_type analog_ctl;
  logic [7:0]     lvl [8] = '{8'h00, 8'h11, 8'h3c, 8'ha5, 8'hff, 8'h01, 8'h7e, 8'hc3};
  int             fails = 0;
  int             cmp_count = 0;
  int             n;

  // Short stop delay keeps the run brief
  sar_adc_sequencer_control #(.SAMPLE_CYCLES(12), .STOP_DELAY(20)) i_sar_adc_sequencer_control (
    .clock, .rst_n, .ctl_access, .ctl_rdata, .opt_access, .opt_rdata, .result_index,
    .result_rdata, .comparator_in, .stop_exit, .stop_hold, .analog_ctl, .dac_trial,
    .sequence_done_flag);
  analog_front_model i_analog_front_model (.clock, .pin_level(lvl), .analog_ctl, .dac_trial,
    .comparator_in);

  initial begin
    forever #10 clock = ~clock;
  end

  // ----------------------------------------------------------------------
  // Access tasks, all entered just after a falling edge
  // ----------------------------------------------------------------------
  task automatic wr_ctl(input logic [7:0] d);
    ctl_access = '{d, 1'b1, 1'b0};
    @(negedge clock);
    ctl_access.wr = 1'b0;
    @(negedge clock); // Strobe stays low a cycle before any next write
  endtask : wr_ctl
  task automatic wr_opt(input logic [7:0] d);
    opt_access = '{d, 1'b1, 1'b0};
    @(negedge clock);
    opt_access.wr = 1'b0;
    @(negedge clock); // Strobe stays low a cycle before any next write
  endtask : wr_opt
  // Result data is registered, so it is looked at one cycle after the index
  task automatic rd_res(input logic [1:0] i, input logic [7:0] e);
    result_index = i;
    @(negedge clock);
    `chk_eq("result", e, result_rdata)
  endtask : rd_res
  task automatic rd_all(input logic [7:0] e0, e1, e2, e3);
    rd_res(2'h0, e0);
    rd_res(2'h1, e1);
    rd_res(2'h2, e2);
    rd_res(2'h3, e3);
  endtask : rd_all
  task automatic wait_done;
    n = 0;
    while (sequence_done_flag !== 1'b1 && n < 400) begin
      @(negedge clock);
      n++;
    end
    `chk_eq("done flag", 1'b1, sequence_done_flag)
  endtask : wait_done
  task automatic stop_len(input logic [7:0] opt, output int c);
    wr_opt(opt);
    stop_exit = 1'b1;
    @(negedge clock);
    stop_exit = 1'b0;
    c = 0;
    while (stop_hold === 1'b1 && c < 100) begin
      @(negedge clock);
      c++;
    end
  endtask : stop_len
  task automatic conclude;
    if (fails == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    `chk_eq("ctl reset", 8'h00, ctl_rdata)
    `chk_eq("opt reset", 8'h10, opt_rdata)
    `chk_eq("pump reset", 1'b0, analog_ctl.pump_on)
    wr_opt(8'hff);
    `chk_eq("opt mask", 8'hd0, opt_rdata)
    `chk_eq("clock sel", 1'b1, analog_ctl.clock_select)
    wr_opt(8'h80);
    `chk_eq("clock sel", 1'b0, analog_ctl.clock_select)
    repeat (5000) @(negedge clock);
    wr_ctl(8'h43);
    `chk_eq("ctl bits", 8'h03, ctl_rdata)
    wait_done;
    `chk_eq("ctl done", 8'h83, ctl_rdata)
    rd_all(lvl[3], lvl[3], lvl[3], lvl[3]);
    // Powered down: a write must leave results alone
    wr_opt(8'h00);
    wr_ctl(8'h05);
    repeat (120) @(negedge clock);
    rd_all(lvl[3], lvl[3], lvl[3], lvl[3]);
    wr_opt(8'h80);
    repeat (5000) @(negedge clock);
    // Group mode, low select bits set to show they are ignored
    for (int g = 0; g < 2; g++) begin
      wr_ctl(8'h13 | 8'(g << 2));
      wait_done;
      rd_all(lvl[4*g], lvl[4*g+1], lvl[4*g+2], lvl[4*g+3]);
    end
    wr_ctl(8'h1c);
    wait_done;
    rd_res(2'h0, 8'hff);
    rd_res(2'h1, 8'h00);
    rd_res(2'h2, 8'h80);
    // Continuous single channel keeps updating with the flag up
    wr_ctl(8'h20);
    wait_done;
    lvl[0] = 8'h5b;
    repeat (200) @(negedge clock);
    `chk_eq("flag kept", 1'b1, sequence_done_flag)
    rd_all(8'h5b, 8'h5b, 8'h5b, 8'h5b);
    // Rewrite in mid-run abandons the old run
    wr_ctl(8'h01);
    `chk_eq("flag cleared", 1'b0, sequence_done_flag)
    repeat (30) @(negedge clock);
    wr_ctl(8'h02);
    wait_done;
    rd_all(lvl[2], lvl[2], lvl[2], lvl[2]);
    repeat (60) @(negedge clock);
    `chk_eq("stopped", 1'b0, analog_ctl.sample_closed)
    // Stop exit with and without the long delay
    stop_len(8'h90, n);
    `chk_eq("long hold", 1'b1, n >= 18 && n <= 22)
    stop_len(8'h80, n);
    `chk_eq("short hold", 1'b1, n >= 2 && n <= 6)
    conclude;
  end

  // Watchdog, well beyond the roughly 12000 cycles the tests need with settling waits
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    conclude;
  end
endmodule : test_sar_adc_sequencer_control
`default_nettype wire
